// *** logic/acq_regs_pkg.sv ***
// Package with register map, field positions and reset values of the acquisition registers
package acq_regs_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [15:0] CHAN_CONFIG_OFF = 16'h8000;
    localparam logic [15:0] CONFIG_BIT_CLEAR_OFF = 16'h8008;
    localparam logic [15:0] BUFFER_ORGANISATION_OFF = 16'h800C;
    localparam logic [15:0] BUFFER_RELEASE_OFF = 16'h8010;
    localparam logic [15:0] FIXED_EVENT_LENGTH_OFF = 16'h8020;
    localparam logic [15:0] ACQUISITION_CONTROL_OFF = 16'h8100;
    localparam logic [15:0] ACQUISITION_STATUS_OFF = 16'h8104;
    localparam logic [15:0] SOFTWARE_TRIGGER_OFF = 16'h8108;
    localparam logic [15:0] TRIGGER_COUNT_OFF = 16'h8140;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int DENSE_PACKING_BIT = 11;
    localparam int CODE_W = 4;
    localparam logic [3:0] MAX_CODE = 4'hA;
    localparam int RELEASE_W = 12;
    localparam int CTRL_COUNT_ALL_BIT = 3;
    localparam int CTRL_RUN_BIT = 2;
    localparam int STAT_READY_BIT = 8;
    localparam int STAT_PLL_OK_BIT = 7;
    localparam int STAT_BYPASS_BIT = 6;
    localparam int STAT_CLK_EXT_BIT = 5;
    localparam int STAT_FULL_BIT = 4;
    localparam int STAT_EVT_READY_BIT = 3;
    localparam int STAT_RUN_BIT = 2;

    // ------------------------------------------------------------
    // Reset values and sizes in samples
    // ------------------------------------------------------------
    localparam logic [31:0] CHAN_CONFIG_RST = 32'h0000_0010;
    localparam logic [3:0] CODE_RST = 4'h0;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [4:0] PIN_SYNC_RST = 5'h02;
    localparam logic [23:0] SMALL_STD_SAMPLES = 24'h10_0000;
    localparam logic [23:0] SMALL_DENSE_SAMPLES = 24'h14_0000;
    localparam logic [23:0] LARGE_STD_SAMPLES = 24'h80_0000;
    localparam logic [23:0] LARGE_DENSE_SAMPLES = 24'hA0_0000;

    // ------------------------------------------------------------
    // Run modes and run state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_REGISTER = 2'b00,
        MODE_SYNC_RUN = 2'b01,
        MODE_SYNC_GATE = 2'b10,
        MODE_SYNC_ONLY = 2'b11
    } run_mode_t;

    typedef enum logic [2:0] {
        ST_STOPPED = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUNNING = 3'b100
    } run_state_t;

endpackage : acq_regs_pkg

// *** logic/acq_regs.sv ***
// Acquisition buffer and run control register bank with an APB slave
//
// Notes on behaviour
// - Clear write zeroes config bits written one
// - Code splits buffer into 2^code blocks
// - Block size halves per code step
// - Organisation write fires a software clear
// - Release write frees first N blocks
// - Zero length disables; else locations per event
// - Control bit 3 counts accepted or all
// - Setting run starts and resets memory
// - Clearing run stops; triggers ignored while stopped
// - Two-bit field picks one of four modes
// - Register mode: run follows bit, gate open
// - Sync-run mode: sync input starts run
// - Sync-gate mode: sync input gates, no sync
// - Mode 11 only synchronises boards
// - Status bit 8 shows board ready
// - Bit 7 drops on lock loss, read restores
// - Bits 6, 5 show bypass and source
// - Bit 4 set when stored events hit maximum
// - Bit 3 set when an event is stored
// - Any software trigger write makes one trigger
`timescale 1ns/1ps

module acq_regs #(
    parameter bit LARGE_MEMORY = 1'b0,
    parameter int COUNT_W = 32
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_in,
    input wire logic pll_locked,
    input wire logic adc_synced,
    input wire logic pll_bypass,
    input wire logic clk_external,
    input wire logic ext_trigger,
    input wire logic rejected_trigger,
    input wire logic [10:0] stored_events,
    output logic [31:0] chan_config,
    output logic dense_packing_mode,
    output logic [3:0] block_code,
    output logic [10:0] block_count,
    output logic [23:0] block_samples,
    output logic software_clear,
    output logic memory_reset,
    output logic release_pulse,
    output logic [11:0] release_count,
    output logic fixed_len_enable,
    output logic [31:0] locations_per_event,
    output logic running,
    output logic gate_open,
    output logic board_sync,
    output logic trigger_accepted
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Counter is read back in one bus word
    if (COUNT_W < 1 || COUNT_W > 32) begin : g_count_w_check
        $error("COUNT_W must lie between 1 and 32");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Codes above the top one are clamped so the block math stays sane
    function automatic logic [3:0] clamp_code(input logic [3:0] code);
        clamp_code = (code > acq_regs_pkg::MAX_CODE) ? acq_regs_pkg::MAX_CODE : code;
    endfunction : clamp_code

    function automatic logic [23:0] base_samples(input logic dense);
        if (LARGE_MEMORY) begin
            base_samples = dense ? acq_regs_pkg::LARGE_DENSE_SAMPLES
                                 : acq_regs_pkg::LARGE_STD_SAMPLES;
        end else begin
            base_samples = dense ? acq_regs_pkg::SMALL_DENSE_SAMPLES
                                 : acq_regs_pkg::SMALL_STD_SAMPLES;
        end
    endfunction : base_samples

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic sync_prev_reg;

    // Two stages; only the second stage is read by logic
    // Lock stages reset high, else every reset would log a lock loss
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_reg <= acq_regs_pkg::PIN_SYNC_RST;
            pin_sync_reg <= acq_regs_pkg::PIN_SYNC_RST;
            sync_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {clk_external, pll_bypass, adc_synced, pll_locked, sync_in};
            pin_sync_reg <= pin_meta_reg;
            sync_prev_reg <= pin_sync_reg[0];
        end
    end

    wire sync_level = pin_sync_reg[0];
    wire sync_rise = pin_sync_reg[0] & ~sync_prev_reg;
    wire lock_now = pin_sync_reg[1];
    wire board_ready = pin_sync_reg[1] & pin_sync_reg[2];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire access = psel & penable & pready;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire hit_cfg = (paddr == acq_regs_pkg::CHAN_CONFIG_OFF);
    wire hit_clr = (paddr == acq_regs_pkg::CONFIG_BIT_CLEAR_OFF);
    wire hit_org = (paddr == acq_regs_pkg::BUFFER_ORGANISATION_OFF);
    wire hit_rel = (paddr == acq_regs_pkg::BUFFER_RELEASE_OFF);
    wire hit_len = (paddr == acq_regs_pkg::FIXED_EVENT_LENGTH_OFF);
    wire hit_ctl = (paddr == acq_regs_pkg::ACQUISITION_CONTROL_OFF);
    wire hit_sta = (paddr == acq_regs_pkg::ACQUISITION_STATUS_OFF);
    wire hit_swt = (paddr == acq_regs_pkg::SOFTWARE_TRIGGER_OFF);
    wire hit_cnt = (paddr == acq_regs_pkg::TRIGGER_COUNT_OFF);
    wire rd_only = hit_sta | hit_cnt;
    wire wr_only = hit_clr | hit_swt;
    wire mapped = hit_cfg | hit_clr | hit_org | hit_rel | hit_len | hit_ctl | rd_only | hit_swt;
    wire bad = ~mapped | (pwrite & rd_only) | (~pwrite & wr_only);
    wire wr_ok = wr & ~bad;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] cfg_reg;
    logic [3:0] code_reg;
    logic [11:0] release_reg;
    logic [31:0] len_reg;
    logic [3:0] ctrl_reg;
    logic pll_ok_reg;
    logic [COUNT_W-1:0] count_reg;
    acq_regs_pkg::run_state_t state_reg;
    acq_regs_pkg::run_state_t state_next;

    wire [1:0] mode_bits = ctrl_reg[1:0];
    wire run_bit = ctrl_reg[acq_regs_pkg::CTRL_RUN_BIT];
    wire count_all = ctrl_reg[acq_regs_pkg::CTRL_COUNT_ALL_BIT];

    // Configuration write and selective clear
    wire [31:0] cfg_next = (wr_ok & hit_cfg) ? pwdata
                         : (wr_ok & hit_clr) ? (cfg_reg & ~pwdata)
                         : cfg_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= acq_regs_pkg::CHAN_CONFIG_RST;
            code_reg <= acq_regs_pkg::CODE_RST;
            release_reg <= 12'h000;
            len_reg <= 32'h0000_0000;
            ctrl_reg <= acq_regs_pkg::CTRL_RST;
        end else begin
            cfg_reg <= cfg_next;
            if (wr_ok & hit_org) begin
                code_reg <= pwdata[3:0];
            end
            if (wr_ok & hit_rel) begin
                release_reg <= pwdata[11:0];
            end
            if (wr_ok & hit_len) begin
                len_reg <= pwdata;
            end
            if (wr_ok & hit_ctl) begin
                ctrl_reg <= pwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    // Sync-run mode waits armed until the sync input rises
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            acq_regs_pkg::ST_STOPPED: begin
                if (run_bit) begin
                    if (mode_bits == acq_regs_pkg::MODE_SYNC_RUN) begin
                        state_next = acq_regs_pkg::ST_ARMED;
                    end else begin
                        state_next = acq_regs_pkg::ST_RUNNING;
                    end
                end
            end
            acq_regs_pkg::ST_ARMED: begin
                if (!run_bit) begin
                    state_next = acq_regs_pkg::ST_STOPPED;
                end else if (sync_rise) begin
                    state_next = acq_regs_pkg::ST_RUNNING;
                end
            end
            acq_regs_pkg::ST_RUNNING: begin
                if (!run_bit) begin
                    state_next = acq_regs_pkg::ST_STOPPED;
                end
            end
            default: state_next = acq_regs_pkg::ST_STOPPED;
        endcase
    end

    wire run_next = (state_next == acq_regs_pkg::ST_RUNNING);
    wire run_start = run_next & (state_reg != acq_regs_pkg::ST_RUNNING);

    // Gate is the sync level in gate mode, open otherwise
    wire gate_next = (mode_bits == acq_regs_pkg::MODE_SYNC_GATE) ? sync_level : 1'b1;

    // Sync pulse is forwarded for board alignment except in gate mode
    wire sync_next = sync_rise & (mode_bits != acq_regs_pkg::MODE_SYNC_GATE);

    // ------------------------------------------------------------
    // Triggers and counting
    // ------------------------------------------------------------
    wire sw_trig = wr_ok & hit_swt;
    wire any_trig = sw_trig | ext_trigger;
    wire accept = any_trig & running & gate_open;
    wire count_it = running & (accept | (count_all & rejected_trigger));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= acq_regs_pkg::ST_STOPPED;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (run_start) begin
                count_reg <= '0;
            end else if (count_it) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Lock flag
    // ------------------------------------------------------------
    // Loss of lock beats a restoring read in the same cycle
    // Level based: no read restores it while lock stays low
    wire pll_ok_next = !lock_now ? 1'b0 : ((rd & hit_sta) ? 1'b1 : pll_ok_reg);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pll_ok_reg <= 1'b1;
        end else begin
            pll_ok_reg <= pll_ok_next;
        end
    end

    // ------------------------------------------------------------
    // Status word and read mux
    // ------------------------------------------------------------
    wire [10:0] max_events = 11'(11'h001 << clamp_code(code_reg));
    wire evt_full = (stored_events >= max_events);
    wire evt_ready = (stored_events != 11'h000);

    wire [31:0] status_word = {23'h000000, board_ready, pll_ok_reg,
                               pin_sync_reg[3], pin_sync_reg[4],
                               evt_full, evt_ready, running, 2'b00};

    wire [31:0] rd_mux = hit_cfg ? cfg_reg
                       : hit_org ? {28'h0000000, code_reg}
                       : hit_rel ? {20'h00000, release_reg}
                       : hit_len ? len_reg
                       : hit_ctl ? {28'h0000000, ctrl_reg}
                       : hit_sta ? status_word
                       : hit_cnt ? 32'(count_reg)
                       : 32'h0000_0000;

    // One wait state: pready rises on the second access cycle
    wire pready_next = psel & penable & ~pready;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= pready_next;
            pslverr <= pready_next & bad;
            prdata <= (pready_next & ~pwrite & ~bad) ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Derived outputs, all registered
    // ------------------------------------------------------------
    wire dense_next = cfg_next[acq_regs_pkg::DENSE_PACKING_BIT];
    wire [3:0] code_next = (wr_ok & hit_org) ? pwdata[3:0] : code_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chan_config <= acq_regs_pkg::CHAN_CONFIG_RST;
            dense_packing_mode <= 1'b0;
            block_code <= acq_regs_pkg::CODE_RST;
            block_count <= 11'h001;
            block_samples <= LARGE_MEMORY ? acq_regs_pkg::LARGE_STD_SAMPLES
                                          : acq_regs_pkg::SMALL_STD_SAMPLES;
            software_clear <= 1'b0;
            memory_reset <= 1'b0;
            release_pulse <= 1'b0;
            release_count <= 12'h000;
            fixed_len_enable <= 1'b0;
            locations_per_event <= 32'h0000_0000;
            running <= 1'b0;
            gate_open <= 1'b1;
            board_sync <= 1'b0;
            trigger_accepted <= 1'b0;
        end else begin
            chan_config <= cfg_next;
            dense_packing_mode <= dense_next;
            block_code <= code_next;
            block_count <= 11'(11'h001 << clamp_code(code_next));
            block_samples <= base_samples(dense_next) >> clamp_code(code_next);
            software_clear <= wr_ok & hit_org;
            memory_reset <= run_start;
            release_pulse <= wr_ok & hit_rel;
            release_count <= (wr_ok & hit_rel) ? pwdata[11:0] : release_count;
            fixed_len_enable <= ((wr_ok & hit_len) ? pwdata : len_reg) != 32'h0000_0000;
            locations_per_event <= (wr_ok & hit_len) ? pwdata : len_reg;
            running <= run_next;
            gate_open <= gate_next;
            board_sync <= sync_next;
            trigger_accepted <= accept;
        end
    end

endmodule : acq_regs

// *** verif/acq_regs_chk.sv ***
// Checker of the acquisition register bank port behaviour
`timescale 1ns/1ps

module acq_regs_chk #(
    parameter bit LARGE_MEMORY = 1'b0
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] chan_config,
    input wire logic dense_packing_mode,
    input wire logic [3:0] block_code,
    input wire logic [10:0] block_count,
    input wire logic [23:0] block_samples,
    input wire logic software_clear,
    input wire logic memory_reset,
    input wire logic release_pulse,
    input wire logic [11:0] release_count,
    input wire logic fixed_len_enable,
    input wire logic [31:0] locations_per_event,
    input wire logic running,
    input wire logic trigger_accepted
);
    // --------------------------------------------------------
    // Helper decode
    // --------------------------------------------------------
    // Codes above ten clamp, so block math never overflows
    wire logic done = psel && penable && pready && !pslverr;
    wire logic wr_ok = done && pwrite;
    wire logic [3:0] eff = (block_code > 4'hA) ? 4'hA : block_code;
    wire logic [23:0] base_large = dense_packing_mode ? 24'hA0_0000 : 24'h80_0000;
    wire logic [23:0] base_small = dense_packing_mode ? 24'h14_0000 : 24'h10_0000;
    wire logic [23:0] base = LARGE_MEMORY ? base_large : base_small;
    wire logic [11:0] wlow = pwdata[11:0];

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // --------------------------------------------------------
    // Assertions
    // --------------------------------------------------------
    a_block_count: assert property (block_count == (11'h1 << eff))
        else $error("block count does not match code");
    a_block_size: assert property (block_samples == (base >> eff))
        else $error("block size does not match code");
    a_dense_mirror: assert property (dense_packing_mode == chan_config[11])
        else $error("dense packing flag differs from config");
    a_len_enable: assert property (fixed_len_enable == (locations_per_event != 32'h0))
        else $error("fixed length enable wrong");
    a_cfg_clear: assert property (wr_ok && paddr == 16'h8008 && pwdata[31:8] == 24'h0
        |=> chan_config == ($past(chan_config) & ~$past(pwdata))) else $error("bit clear wrong");
    a_org_clear: assert property (wr_ok && paddr == 16'h800C |=> software_clear)
        else $error("organisation write gave no software clear");
    a_release_val: assert property (wr_ok && paddr == 16'h8010
        |=> release_pulse && release_count == $past(wlow)) else $error("release wrong");
    a_run_reset: assert property ($rose(running) |-> memory_reset)
        else $error("run start without memory reset");
    a_stop_ignore: assert property (!running |=> !trigger_accepted)
        else $error("trigger accepted while stopped");
    a_status_run: assert property (done && !pwrite && paddr == 16'h8104
        |-> prdata[2] == $past(running)) else $error("status run bit wrong");
endmodule : acq_regs_chk

bind acq_regs acq_regs_chk #(.LARGE_MEMORY(LARGE_MEMORY)) u_acq_regs_chk (.ref_clk, .nrst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .chan_config,
    .dense_packing_mode, .block_code, .block_count, .block_samples, .software_clear,
    .memory_reset, .release_pulse, .release_count, .fixed_len_enable, .locations_per_event,
    .running, .trigger_accepted);

// *** verif/acq_regs_tb.sv ***
// Self-checking testbench of the acquisition register bank
`timescale 1ns/1ps

module acq_regs_tb;
    logic ref_clk, nrst, psel, penable, pwrite, sync_in, pll_locked, adc_synced, pll_bypass;
    logic clk_external, ext_trigger, rejected_trigger, pready, pslverr, dense_packing_mode;
    logic software_clear, memory_reset, release_pulse, fixed_len_enable, running, gate_open;
    logic board_sync, trigger_accepted, err, bs;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, chan_config, locations_per_event, rd;
    logic [10:0] stored_events, block_count;
    logic [3:0] block_code;
    logic [23:0] block_samples;
    logic [11:0] release_count;
    int failures, checks;
    typedef struct {logic w; logic [15:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_t;
    // Readback and refused accesses; expected read data of a write is zero
    row_t rows [10] = '{'{1'h1, 16'h800C, 32'h7, 32'h0, 1'h0}, '{1'h0, 16'h800C, 32'h0, 32'h7, 1'h0},
        '{1'h1, 16'h8010, 32'hABC, 32'h0, 1'h0}, '{1'h0, 16'h8010, 32'h0, 32'hABC, 1'h0},
        '{1'h1, 16'h8020, 32'h1234, 32'h0, 1'h0}, '{1'h0, 16'h8020, 32'h0, 32'h1234, 1'h0},
        '{1'h0, 16'h8008, 32'h0, 32'h0, 1'h1}, '{1'h0, 16'h8108, 32'h0, 32'h0, 1'h1},
        '{1'h1, 16'h8104, 32'h5, 32'h0, 1'h1}, '{1'h0, 16'h8200, 32'h0, 32'h0, 1'h1}};

    acq_regs u_acq_regs (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sync_in, .pll_locked, .adc_synced, .pll_bypass, .clk_external,
        .ext_trigger, .rejected_trigger, .stored_events, .chan_config, .dense_packing_mode,
        .block_code, .block_count, .block_samples, .software_clear, .memory_reset,
        .release_pulse, .release_count, .fixed_len_enable, .locations_per_event, .running,
        .gate_open, .board_sync, .trigger_accepted);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Pulse the hardware trigger and watch for acceptance
    task automatic trig_test(input logic exp);
        logic seen;
        @(posedge ref_clk);
        ext_trigger <= 1'h1;
        @(posedge ref_clk);
        ext_trigger <= 1'h0;
        seen = 1'h0;
        repeat (3) begin
            #1 seen |= trigger_accepted;
            @(posedge ref_clk);
        end
        chk(seen, exp, "trigger acceptance");
    endtask : trig_test

    // Sync pin low, then a rising edge; slow enough for the two-stage synchroniser
    task automatic sync_rise();
        sync_in <= 1'h0;
        repeat (5) @(posedge ref_clk);
        sync_in <= 1'h1;
        bs = 1'h0;
        repeat (6) begin
            @(posedge ref_clk);
            #1 bs |= board_sync;
        end
    endtask : sync_rise

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Whole sequence needs about 280 cycles; allow ample margin
    initial begin
        #400_000;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, sync_in, pll_bypass, clk_external} = 7'h0;
        {ext_trigger, rejected_trigger, pll_locked, adc_synced} = 4'h3;
        paddr = 16'h0;
        pwdata = 32'h0;
        stored_events = 11'h0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'h1;
        #1 chk(chan_config, 32'h10, "config reset");
        chk(block_count, 32'h1, "count reset");
        chk(block_samples, 32'h10_0000, "size reset");
        chk(running, 32'h0, "run reset");
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(rd, rows[i].r, "read data");
            chk(err, rows[i].e, "error response");
        end
        // Every code, plus an out-of-range one that must clamp; all while stopped
        for (int c = 0; c < 12; c++) begin
            apb(1'h1, 16'h800C, 32'(c));
            #1 chk(software_clear, 32'h1, "software clear");
            chk(block_count, 32'h1 << (c > 10 ? 10 : c), "block count");
            chk(block_samples, 32'h10_0000 >> (c > 10 ? 10 : c), "block size");
        end
        // Dense packing on, then cleared through the bit-clear location
        apb(1'h1, 16'h8000, 32'h812);
        apb(1'h1, 16'h800C, 32'h1);
        #1 chk(block_samples, 32'hA_0000, "dense block size");
        apb(1'h1, 16'h8008, 32'h802);
        #1 chk(chan_config, 32'h10, "bit clear");
        chk(block_samples, 32'h8_0000, "standard block size");
        apb(1'h1, 16'h8020, 32'h30);
        #1 chk(locations_per_event, 32'h30, "length value");
        chk(fixed_len_enable, 32'h1, "length enabled");
        apb(1'h1, 16'h8020, 32'h0);
        #1 chk(fixed_len_enable, 32'h0, "length disabled");
        apb(1'h1, 16'h8010, 32'hFFFF_F00A);
        #1 chk(release_count, 32'hA, "release count");
        chk(release_pulse, 32'h1, "release pulse");
        // Status word: sticky lock, pins and event flags with four blocks
        apb(1'h1, 16'h800C, 32'h2);
        apb(1'h0, 16'h8104, 32'h0);
        chk(rd & 32'h1FC, 32'h180, "status idle");
        {adc_synced, pll_locked, pll_bypass, clk_external} <= 4'h3;
        stored_events <= 11'h4;
        repeat (4) @(posedge ref_clk);
        pll_locked <= 1'h1;
        repeat (4) @(posedge ref_clk);
        apb(1'h0, 16'h8104, 32'h0);
        chk(rd & 32'h1FC, 32'h78, "status after lock loss");
        {adc_synced, pll_bypass, clk_external} <= 3'h4;
        stored_events <= 11'h3;
        repeat (4) @(posedge ref_clk);
        apb(1'h0, 16'h8104, 32'h0);
        chk(rd & 32'h1FC, 32'h188, "status restored");
        // Register-controlled run; stop keeps count and ignores triggers
        apb(1'h1, 16'h8100, 32'h4);
        repeat (2) @(posedge ref_clk);
        #1 chk({running, gate_open}, 32'h3, "register run");
        trig_test(1'h1);
        apb(1'h1, 16'h8108, 32'h0);
        apb(1'h0, 16'h8104, 32'h0);
        chk(rd[2], 32'h1, "status run bit");
        apb(1'h1, 16'h8100, 32'h0);
        trig_test(1'h0);
        apb(1'h1, 16'h8108, 32'h5);
        apb(1'h0, 16'h8140, 32'h0);
        chk(rd, 32'h2, "accepted count");
        // Count-all setting includes rejected triggers
        apb(1'h1, 16'h8100, 32'hC);
        @(posedge ref_clk); // Run state rises one edge after the write
        rejected_trigger <= 1'h1;
        @(posedge ref_clk);
        rejected_trigger <= 1'h0;
        trig_test(1'h1);
        apb(1'h0, 16'h8140, 32'h0);
        chk(rd, 32'h2, "count all");
        // Gate mode: sync pin gates triggers and gives no board sync
        apb(1'h1, 16'h8100, 32'h6);
        repeat (5) @(posedge ref_clk);
        #1 chk({running, gate_open}, 32'h2, "gate closed");
        trig_test(1'h0);
        sync_rise();
        chk({bs, gate_open}, 32'h1, "gate open no sync");
        trig_test(1'h1);
        // Sync-controlled run: armed until a sync rise
        apb(1'h1, 16'h8100, 32'h1);
        apb(1'h1, 16'h8100, 32'h5);
        repeat (4) @(posedge ref_clk);
        #1 chk({running, gate_open}, 32'h1, "armed");
        sync_rise();
        chk({running, bs}, 32'h3, "sync start");
        // Sync-only mode: sync pin only synchronises
        apb(1'h1, 16'h8100, 32'h3);
        apb(1'h1, 16'h8100, 32'h7);
        sync_rise();
        chk({running, gate_open, bs}, 32'h7, "sync only");
        apb(1'h1, 16'h8100, 32'h3);
        print_verdict();
    end
endmodule : acq_regs_tb
